/* File: common/arc_pkg.sv */
// Shared constants and types for the converter result and sleep noise canceler block.
// Assumes a 32-bit classic Wishbone register bus and a comparator-based SAR analog front end.
package arc_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_SEL = 5'h08;
  localparam logic [4:0] OFF_RLO = 5'h0c;
  localparam logic [4:0] OFF_RHI = 5'h10;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_IE_BIT = 2;
  localparam int CTRL_PS_LSB = 4;

  // Status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_FIRST_BIT = 2;

  // Input and reference select register fields
  localparam int SEL_CHAN_LSB = 0;
  localparam int SEL_LADJ_BIT = 5;
  localparam int SEL_REF_LSB = 6;

  // Reference select codes
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_RSVD = 2'h2;
  localparam logic [1:0] REF_INT = 2'h3;

  // Channel codes that select a differential pair
  localparam logic [4:0] DIFF_FIRST = 5'h08;
  localparam logic [4:0] DIFF_LAST = 5'h1d;

  // Conversion timing in converter clock cycles, SAR start bit and code, prescaler base
  localparam logic [4:0] CONV_NORMAL_TICKS = 5'h0d;
  localparam logic [4:0] CONV_FIRST_TICKS = 5'h19;
  localparam logic [4:0] TAIL_TICKS = 5'h0b;
  localparam logic [3:0] TOP_BIT = 4'h9;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [8:0] PS_BASE = 9'h002;

  // Sleep state codes from the sleep controller
  localparam logic [2:0] SLP_ACTIVE = 3'h0;
  localparam logic [2:0] SLP_IDLE = 3'h1;
  localparam logic [2:0] SLP_NOISE = 3'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARMED = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_TRIAL = 5'b01000,
    ST_FINISH = 5'b10000
  } arc_fsm_t;

  // Signals toward the analog front end
  typedef struct packed {
    logic [4:0] chan;
    logic [1:0] ref_sel;
    logic bg_en;
    logic sample;
    logic busy;
    logic [9:0] dac;
  } arc_ana_t;

  // Whole state of the block
  typedef struct packed {
    arc_fsm_t st;
    arc_ana_t ana;
    logic [7:0] presc;
    logic [4:0] tick_cnt;
    logic [3:0] idx;
    logic ext;
    logic first;
    logic diff;
    logic [9:0] result;
    logic done;
    logic enable;
    logic irq_en;
    logic [2:0] presc_sel;
    logic [4:0] chan;
    logic ladj;
    logic [1:0] ref_sel;
    logic sleep_arm;
    logic sleep_conv;
    logic [2:0] cmp_sync;
    logic cmp_val;
    logic ack;
    logic [31:0] dat;
    logic wake;
    logic irq;
  } arc_regs_t;

endpackage

/* File: hdl/arc_core.sv */
// Converter control: reference and channel select, SAR sequencing, result formatting,
// and the sleep noise canceler start. Registers sit on a classic Wishbone slave.
// Assumes an analog front end that compares the selected input against DAC_CODE and
// reports input >= code on ANA_CMP_I, settled well within one converter clock period.
//
// Notes on behaviour
// - Single-ended result is unsigned: 0 is ground, 0x3FF is reference less one step.
// - Single-ended input above reference settles at 0x3FF, never wraps low.
// - Differential result is two's complement from 0x200 up to 0x1FF.
// - Top result bit is the sign: one negative, zero positive.
// - Full positive saturates 0x1FF, minus one step 0x3FF, full negative 0x200.
// - Result bytes hold the new result when the done flag reads high.
// - Left adjust clear: right-aligned bytes; set: aligned from high byte top bit.
// - Three reference choices: supply switch, internal 2.56V bandgap, external pin.
// - Idle or low-noise sleep with core halted and interrupt enabled starts one conversion automatically.
// - Completion of the sleep conversion wakes the core and raises its interrupt.
// - Earlier wake by another source still gets the completion request later.
// - Other sleep states never switch the converter off by hardware.
// - Same channel may feed both differential inputs to measure offset.
// - Normal conversion 13 converter clocks, first after enable 25.
// - Each completion writes the result and sets the done flag.
// - Left adjust change reformats the presented bytes at once.
// - Reference field: 00 external, 01 supply, 11 internal, 10 reserved.

`timescale 1ns/1ps
`default_nettype none

module arc_core #(
  parameter logic [2:0] PS_RESET = 3'h0
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [4:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic ANA_CMP_I,
  output arc_pkg::arc_ana_t ANA_CTRL_O,
  input wire logic [2:0] SLEEP_MODE_I,
  input wire logic CORE_HALTED_I,
  input wire logic INT_ACK_I,
  output logic CONV_IRQ_O,
  output logic WAKE_O
);

  arc_pkg::arc_regs_t q;
  arc_pkg::arc_regs_t d;
  logic access;
  logic wr;
  logic tick;
  logic [7:0] term;
  logic [4:0] word_adr;
  logic sw_start;
  logic sleep_ok;
  logic [4:0] sh_end;
  logic [9:0] fmt;
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;

  // Bus decode: one request per Wishbone cycle, ack on the clock after it and for one clock only
  assign access = CYC_I & STB_I & ~q.ack;
  assign wr = access & WE_I & SEL_I[0];
  assign word_adr = {ADR_I[4:2], 2'h0};

  // Prescaler terminal count, divide by 2 shifted left by the select field
  // Limitation: below divide-by-8 the three-flop comparator path outlasts a tick, so trial bits go stale
  assign term = 8'((arc_pkg::PS_BASE << q.presc_sel) - 9'h001);
  assign tick = q.enable & (q.presc == term);

  assign sh_end = (q.ext ? arc_pkg::CONV_FIRST_TICKS : arc_pkg::CONV_NORMAL_TICKS) - arc_pkg::TAIL_TICKS;

  // offset-binary search code turned into two's complement for a pair
  assign fmt = q.diff ? {~q.ana.dac[9], q.ana.dac[8:0]} : q.ana.dac;

  // byte layout follows the live left adjust bit, not the one at completion
  assign lo_byte = q.ladj ? {q.result[1:0], 6'h00} : q.result[7:0];
  assign hi_byte = q.ladj ? q.result[9:2] : {6'h00, q.result[9:8]};

  // sleep start: low-noise or idle sleep, core halted, interrupt enabled, converter ready
  assign sleep_ok = ((SLEEP_MODE_I == arc_pkg::SLP_IDLE) | (SLEEP_MODE_I == arc_pkg::SLP_NOISE))
                    & CORE_HALTED_I & q.enable & q.irq_en & q.sleep_arm & (q.st == arc_pkg::ST_IDLE);

  assign sw_start = wr & (word_adr == arc_pkg::OFF_CTRL) & DAT_I[arc_pkg::CTRL_START_BIT];

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.ack = access;
    d.wake = 1'b0;

    // Comparator: three flops, a change counts once the last two agree
    d.cmp_sync = {q.cmp_sync[1:0], ANA_CMP_I};
    if (q.cmp_sync[1] == q.cmp_sync[2]) begin
      d.cmp_val = q.cmp_sync[2];
    end

    // Prescaler runs only while enabled so a fresh enable starts from a known phase
    if (!q.enable || tick) begin
      d.presc = 8'h00;
    end else begin
      d.presc = q.presc + 8'h01;
    end

    // Sleep entry bookkeeping: one automatic start per trip through active mode
    if (SLEEP_MODE_I == arc_pkg::SLP_ACTIVE) begin
      d.sleep_arm = 1'b1;
    end

    // Conversion sequencer
    case (q.st)
      arc_pkg::ST_IDLE: begin
        if (sleep_ok) begin
          // automatic start once the core has halted
          d.st = arc_pkg::ST_ARMED;
          d.sleep_conv = 1'b1;
          d.sleep_arm = 1'b0;
        end else if (sw_start && q.enable) begin
          d.st = arc_pkg::ST_ARMED;
          d.sleep_conv = 1'b0;
        end
      end
      arc_pkg::ST_ARMED: begin
        if (tick) begin
          // first conversion after enable takes the extended path
          d.st = arc_pkg::ST_SAMPLE;
          d.ext = q.first;
          d.first = 1'b0;
          d.tick_cnt = 5'h00;
        end
      end
      arc_pkg::ST_SAMPLE: begin
        if (tick) begin
          d.tick_cnt = q.tick_cnt + 5'h01;
          if (q.tick_cnt == sh_end - 5'h01) begin
            d.st = arc_pkg::ST_TRIAL;
            d.ana.dac = arc_pkg::SAR_MSB;
            d.idx = arc_pkg::TOP_BIT;
          end
        end
      end
      arc_pkg::ST_TRIAL: begin
        if (tick) begin
          // a bit kept while input stays above the trial code saturates at the top
          d.tick_cnt = q.tick_cnt + 5'h01;
          if (!q.cmp_val) begin
            d.ana.dac[q.idx] = 1'b0;
          end
          if (q.idx == 4'h0) begin
            d.st = arc_pkg::ST_FINISH;
          end else begin
            d.ana.dac[4'(q.idx - 4'h1)] = 1'b1;
            d.idx = q.idx - 4'h1;
          end
        end
      end
      arc_pkg::ST_FINISH: begin
        if (tick) begin
          // result and flag written in the same edge
          d.st = arc_pkg::ST_IDLE;
          d.result = fmt;
          // wake only if the core is still asleep; otherwise the request stands alone
          d.wake = q.sleep_conv & CORE_HALTED_I;
          d.sleep_conv = 1'b0;
        end
      end
      default: begin
        d.st = arc_pkg::ST_IDLE;
      end
    endcase

    // selection follows the register until sampling begins, stays locked through the trials, then follows again at finish
    if ((q.st == arc_pkg::ST_IDLE) || (q.st == arc_pkg::ST_ARMED) || (q.st == arc_pkg::ST_FINISH)) begin
      d.ana.chan = q.chan;
      d.ana.ref_sel = q.ref_sel;
      d.diff = (q.chan >= arc_pkg::DIFF_FIRST) && (q.chan <= arc_pkg::DIFF_LAST);
    end

    // Register writes
    if (wr) begin
      case (word_adr)
        arc_pkg::OFF_CTRL: begin
          d.enable = DAT_I[arc_pkg::CTRL_EN_BIT];
          d.irq_en = DAT_I[arc_pkg::CTRL_IE_BIT];
          d.presc_sel = DAT_I[arc_pkg::CTRL_PS_LSB +: 3];
          if (!q.enable && DAT_I[arc_pkg::CTRL_EN_BIT]) begin
            d.first = 1'b1;
          end
          if (!DAT_I[arc_pkg::CTRL_EN_BIT]) begin
            // Turning off mid-conversion abandons it; the old result stays
            d.st = arc_pkg::ST_IDLE;
            d.sleep_conv = 1'b0;
          end else if (!q.enable && DAT_I[arc_pkg::CTRL_START_BIT]) begin
            // Enable and start in one write gives an extended first conversion
            d.st = arc_pkg::ST_ARMED;
            d.sleep_conv = 1'b0;
          end
        end
        arc_pkg::OFF_STAT: begin
          if (DAT_I[arc_pkg::STAT_DONE_BIT]) begin
            d.done = 1'b0;
          end
        end
        arc_pkg::OFF_SEL: begin
          // reference code passed to the front end as written
          d.chan = DAT_I[arc_pkg::SEL_CHAN_LSB +: 5];
          d.ladj = DAT_I[arc_pkg::SEL_LADJ_BIT];
          d.ref_sel = DAT_I[arc_pkg::SEL_REF_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Interrupt vector fetch also clears the flag
    if (INT_ACK_I) begin
      d.done = 1'b0;
    end

    // completion sets the flag and wins over a clear in the same cycle
    if ((q.st == arc_pkg::ST_FINISH) && tick) begin
      d.done = 1'b1;
    end

    // Register reads, answered one cycle after the request
    if (access && !WE_I) begin
      case (word_adr)
        arc_pkg::OFF_CTRL: begin
          d.dat = {25'h0000000, q.presc_sel, 1'b0, q.irq_en, (q.st != arc_pkg::ST_IDLE), q.enable};
        end
        arc_pkg::OFF_STAT: begin
          d.dat = {29'h00000000, q.first, (q.st != arc_pkg::ST_IDLE), q.done};
        end
        arc_pkg::OFF_SEL: begin
          d.dat = {24'h000000, q.ref_sel, q.ladj, q.chan};
        end
        arc_pkg::OFF_RLO: begin
          // result register only changes at completion
          d.dat = {24'h000000, lo_byte};
        end
        arc_pkg::OFF_RHI: begin
          d.dat = {24'h000000, hi_byte};
        end
        default: begin
          d.dat = 32'h00000000;
        end
      endcase
    end

    // no sleep state, the two above included, touches the enable bit
    d.ana.sample = (d.st == arc_pkg::ST_SAMPLE);
    d.ana.busy = (d.st != arc_pkg::ST_IDLE);
    d.ana.bg_en = (d.ana.ref_sel == arc_pkg::REF_INT);
    // request raised whatever woke the core
    d.irq = d.done & d.irq_en;
  end

  // State register
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      q <= '0;
      q.st <= arc_pkg::ST_IDLE;
      q.presc_sel <= PS_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign DAT_O = q.dat;
  assign ACK_O = q.ack;
  assign ANA_CTRL_O = q.ana;
  assign CONV_IRQ_O = q.irq;
  assign WAKE_O = q.wake;

endmodule

`default_nettype wire

/* File: tb/arc_afe_model.sv */
// Analog front end stand-in: a comparator that sees one input level.
// Assumes the bench holds the level steady for a whole conversion.
`timescale 1ns/1ps
`default_nettype none
module arc_afe_model (
  input wire arc_pkg::arc_ana_t ctrl_i,
  input wire logic [10:0] level_i,
  output logic cmp_o
);
  // ideal reference: no external level is driven, so supply and internal may be swapped
  // and the first result after a switch is already exact here
  // steady input against trial code
  // Levels above 0x3ff stand for an input over the reference
  assign cmp_o = {1'b0, ctrl_i.dac} <= level_i;
endmodule
`default_nettype wire

/* File: tb/arc_core_monitor.sv */
// Checker on the converter core ports, bound into every arc_core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module arc_core_monitor (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [4:0] ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire arc_pkg::arc_ana_t ANA_CTRL_O,
  input wire logic CORE_HALTED_I,
  input wire logic CONV_IRQ_O,
  input wire logic WAKE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Request taken by the slave, and a read of an unmapped word
  sequence bus_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence hole_rd;
    bus_req ##0 (!WE_I && ADR_I[4:2] > 3'h4);
  endsequence
  ack_next_a: assert property (bus_req |=> ACK_O) else $error("ack missing");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  hole_zero_a: assert property (hole_rd |=> DAT_O == 32'h0) else $error("unmapped read not zero");
  bg_match_a:
    assert property (ANA_CTRL_O.bg_en == (ANA_CTRL_O.ref_sel == arc_pkg::REF_INT)) else $error("bandgap enable");
  sample_busy_a:
    assert property (ANA_CTRL_O.sample |-> ANA_CTRL_O.busy) else $error("sample while idle");
  busy_min_a:
    assert property ($rose(ANA_CTRL_O.busy) |-> ANA_CTRL_O.busy [*8]) else $error("conversion too short");
  wake_halt_a:
    assert property (WAKE_O |-> $past(CORE_HALTED_I)) else $error("wake while running");
  wake_once_a:
    assert property (WAKE_O |=> !WAKE_O) else $error("wake too long");
  wake_irq_a:
    assert property (WAKE_O |-> ##[0:2] CONV_IRQ_O) else $error("wake without request");
endmodule
bind arc_core arc_core_monitor MON (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ANA_CTRL_O(ANA_CTRL_O),
  .CORE_HALTED_I(CORE_HALTED_I), .CONV_IRQ_O(CONV_IRQ_O), .WAKE_O(WAKE_O));
`default_nettype wire

/* File: tb/test_adc_result_and_sleep_noise_canceler.sv */
// Self-checking bench: bus, result format, conversion time, sleep start.
// Assumes the core, checker bind and front end model compile first.
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_and_sleep_noise_canceler;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dout, rdat;
  logic [10:0] level = 11'h000;
  logic [2:0] slp = 3'h0;
  logic halted = 1'b0, iack = 1'b0, ack, cmp, irq, wake;
  arc_pkg::arc_ana_t ana;
  int miscompares = 0;
  int samples_checked = 0;
  // Divide by 8: the comparator synchroniser needs about four clocks to follow a new trial code
  localparam int TICK = 8;
  // Enable, start, interrupt enable, prescale select 2
  localparam logic [31:0] CTRL_RUN = 32'h00000027;
  // Busy is first seen two edges after the start write is taken
  localparam int FIRST_LO = 26 * TICK - 2;
  localparam int FIRST_HI = 26 * TICK;
  localparam int NORM_LO = 13 * TICK - 1;
  localparam int NORM_HI = 14 * TICK + 1;

  arc_core DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(dout), .ACK_O(ack), .ANA_CMP_I(cmp), .ANA_CTRL_O(ana),
    .SLEEP_MODE_I(slp), .CORE_HALTED_I(halted), .INT_ACK_I(iack), .CONV_IRQ_O(irq), .WAKE_O(wake));
  arc_afe_model AFE (.ctrl_i(ana), .level_i(level), .cmp_o(cmp));

  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle held until ack; read data taken at the ack edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rdat, exp);
  endtask

  // Every reference code, masked write and unmapped word
  task automatic refs;
    int r;
    for (r = 0; r < 4; r++) begin
      wr(arc_pkg::OFF_SEL, {24'h0, 2'(r), 6'h0});
      rd(arc_pkg::OFF_SEL, {24'h0, 2'(r), 6'h0});
      check({30'h0, ana.ref_sel}, 32'(r));
      check({31'h0, ana.bg_en}, {31'h0, r == 3});
    end
    bus(1'b1, arc_pkg::OFF_SEL, 32'h3f, 4'he);
    rd(arc_pkg::OFF_SEL, 32'hc0);
    wr(5'h14, 32'hff);
    rd(5'h14, 32'h0);
  endtask

  // Start, time the busy span, then read both alignments
  task automatic convert(input logic [4:0] ch, input logic [10:0] lv, input logic [9:0] exp, input int lo,
    input int hi);
    int cnt;
    int k;
    cnt = 0;
    level <= lv;
    wr(arc_pkg::OFF_SEL, {24'h0, arc_pkg::REF_SUPPLY, 1'b0, ch});
    wr(arc_pkg::OFF_CTRL, CTRL_RUN);
    for (k = 0; k < 400 && (cnt == 0 || ana.busy === 1'b1); k++) begin
      @(posedge clk);
      if (ana.busy === 1'b1) cnt++;
    end
    if (k >= 400) begin
      miscompares++;
      complete_run();
    end
    check(32'(cnt >= lo && cnt <= hi), 32'h1);
    rd(arc_pkg::OFF_STAT, 32'h1);
    rd(arc_pkg::OFF_RLO, {24'h0, exp[7:0]});
    rd(arc_pkg::OFF_RHI, {30'h0, exp[9:8]});
    wr(arc_pkg::OFF_SEL, {24'h0, arc_pkg::REF_SUPPLY, 1'b1, ch});
    rd(arc_pkg::OFF_RLO, {24'h0, exp[1:0], 6'h0});
    rd(arc_pkg::OFF_RHI, {24'h0, exp[9:2]});
    wr(arc_pkg::OFF_STAT, 32'h1);
  endtask

  // Halt in a sleep state; optionally wake early by another source
  task automatic sleep_run(input logic [2:0] m, input logic early, input logic [9:0] exp);
    int k;
    int w;
    logic sb;
    w = 0;
    sb = 1'b0;
    level <= {1'b0, exp};
    wr(arc_pkg::OFF_SEL, {24'h0, arc_pkg::REF_SUPPLY, 6'h03});
    slp <= m;
    halted <= 1'b1;
    for (k = 0; k < 400 && !(sb && ana.busy !== 1'b1); k++) begin
      @(posedge clk);
      if (ana.busy === 1'b1) sb = 1'b1;
      if (wake === 1'b1) w++;
      if (k == 8 && early) begin
        halted <= 1'b0;
        slp <= arc_pkg::SLP_ACTIVE;
      end
    end
    if (k >= 400) begin
      miscompares++;
      complete_run();
    end
    repeat (3) begin
      @(posedge clk);
      if (wake === 1'b1) w++;
    end
    check(32'(w), early ? 32'h0 : 32'h1);
    check({31'h0, irq}, 32'h1);
    slp <= arc_pkg::SLP_ACTIVE;
    halted <= 1'b0;
    rd(arc_pkg::OFF_RLO, {24'h0, exp[7:0]});
    iack <= 1'b1;
    @(posedge clk);
    iack <= 1'b0;
    rd(arc_pkg::OFF_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  // Other sleep state: no start, enable left alone
  task automatic other_sleep;
    int k;
    logic b;
    b = 1'b0;
    slp <= 3'h3;
    halted <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (ana.busy === 1'b1) b = 1'b1;
    end
    check({31'h0, b}, 32'h0);
    rd(arc_pkg::OFF_CTRL, CTRL_RUN & 32'hfffffffd);
    slp <= arc_pkg::SLP_ACTIVE;
    halted <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i != 1) rd(5'(i * 4), 32'h0);
    end
    refs();
    convert(5'h00, 11'h155, 10'h155, FIRST_LO, FIRST_HI);
    convert(5'h00, 11'h000, 10'h000, NORM_LO, NORM_HI);
    convert(5'h01, 11'h7ff, 10'h3ff, NORM_LO, NORM_HI);
    convert(5'h10, 11'h3ff, 10'h1ff, NORM_LO, NORM_HI);
    convert(5'h10, 11'h1ff, 10'h3ff, NORM_LO, NORM_HI);
    convert(5'h08, 11'h000, 10'h200, NORM_LO, NORM_HI);
    sleep_run(arc_pkg::SLP_NOISE, 1'b0, 10'h2a5);
    sleep_run(arc_pkg::SLP_IDLE, 1'b1, 10'h0f0);
    other_sleep();
    wr(arc_pkg::OFF_CTRL, 32'h0);
    convert(5'h12, 11'h280, 10'h080, FIRST_LO, FIRST_HI);
    complete_run();
  end
endmodule
`default_nettype wire
